/* logic/pit_top.sv */
// Periodic interval timer with APB register slave and event interrupt
`timescale 1ns/10ps
`default_nettype none
`include "pit_cfg.svh"
// Functional notes
// - Period equals reload count over input clock divided by prescaler.
// - Reload zero gives 65536 ticks; reload one gives one tick.
// - Prescaler field resets to code zero, divide by four.
// - Run bit clear holds count; setting it restarts from the written reload value.
// - Interrupt enable clear blocks request; counting continues regardless.
// - Counter reaching zero sets the expiry flag.
// - Flag clears by writing zero after reading one; writing one keeps it.
// - Reserved control bits read zero; access allowed any time.
// - Control layout: run, irq enable, prescaler, flag, reload count.
// - Count register is read-only live count; reads do not disturb.
// - Request goes out to the interrupt controller.
// - At the zero crossing, counter reloads on that same tick and repeats.
// - Writing reload count restarts countdown from new value.
// - Prescaler codes zero to four divide by 4 to 64.
// - Request stays pending until the flag is cleared.
module pit_top
	import pit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o
);

	pit_bus_state_t state;
	logic run_enable;
	logic interrupt_enable;
	logic [2:0] prescaler_select;
	logic expiry_flag;
	logic clear_armed;
	logic [15:0] reload_count;
	logic [15:0] live_count;
	logic [`PIT_EVT_WIDTH-1:0] evt_status;
	logic [`PIT_EVT_WIDTH-1:0] evt_enable;
	logic tick;
	logic tick_en;
	logic expire;
	logic commit;
	logic ctrl_wr;
	logic clr_wr;
	logic ctrl_rd;
	logic [31:0] ctrl_view;
	logic [31:0] next_rdata;
	logic next_err;

	// Next count: one wraps to reload, so reload zero spans 65536 ticks
	function automatic logic [15:0] pit_next_count(input logic [15:0] cur,
		input logic [15:0] rld);
		return (cur == `PIT_COUNT_ONE) ? rld : cur - `PIT_COUNT_ONE;
	endfunction

	function automatic logic pit_mapped(input logic [31:0] a);
		return a == `PIT_ADDR_CTRL || a == `PIT_ADDR_COUNT ||
			a == `PIT_ADDR_EVT_STATUS || a == `PIT_ADDR_EVT_CLEAR ||
			a == `PIT_ADDR_EVT_ENABLE;
	endfunction

	// Transfer completes where the registered pready is sampled high
	assign commit = psel_i && penable_i && pready_o;
	assign ctrl_wr = commit && pwrite_i && paddr_i == `PIT_ADDR_CTRL;
	assign clr_wr = commit && pwrite_i && paddr_i == `PIT_ADDR_EVT_CLEAR;
	assign ctrl_rd = commit && !pwrite_i && paddr_i == `PIT_ADDR_CTRL;
	assign tick_en = tick && run_enable;
	// terminal tick is the zero crossing
	assign expire = tick_en && live_count == `PIT_COUNT_ONE;

	always_comb begin
		ctrl_view = `PIT_CTRL_RESET;
		ctrl_view[`PIT_RUN_BIT] = run_enable;
		ctrl_view[`PIT_IEN_BIT] = interrupt_enable;
		ctrl_view[`PIT_PSC_HI:`PIT_PSC_LO] = prescaler_select;
		ctrl_view[`PIT_FLAG_BIT] = expiry_flag;
		ctrl_view[`PIT_RELOAD_HI:`PIT_RELOAD_LO] = reload_count;
	end

	// reads answered at any time; count read has no side effect
	always_comb begin
		next_rdata = `PIT_CTRL_RESET;
		next_err = 1'b0;
		if (!pwrite_i) begin
			if (paddr_i == `PIT_ADDR_CTRL) begin
				next_rdata = ctrl_view & `PIT_CTRL_READ_MASK;
			end else if (paddr_i == `PIT_ADDR_COUNT) begin
				next_rdata[15:0] = live_count;
			end else if (paddr_i == `PIT_ADDR_EVT_STATUS) begin
				next_rdata[`PIT_EVT_WIDTH-1:0] = evt_status;
			end else if (paddr_i == `PIT_ADDR_EVT_ENABLE) begin
				next_rdata[`PIT_EVT_WIDTH-1:0] = evt_enable;
			end
		end
		if (!pit_mapped(paddr_i)) begin
			next_err = 1'b1;
		end
	end

	// One wait state: answer registered in the first access cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= PIT_BUS_IDLE;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= `PIT_CTRL_RESET;
		end else begin
			unique case (state)
				PIT_BUS_IDLE: begin
					if (psel_i && penable_i) begin
						state <= PIT_BUS_RESP;
						pready_o <= 1'b1;
						pslverr_o <= next_err;
						prdata_o <= next_rdata;
					end
				end
				PIT_BUS_RESP: begin
					state <= PIT_BUS_DONE;
					pready_o <= 1'b0;
					pslverr_o <= 1'b0;
				end
				PIT_BUS_DONE: begin
					state <= PIT_BUS_IDLE;
				end
				default: begin
					state <= PIT_BUS_IDLE;
					pready_o <= 1'b0;
					pslverr_o <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			run_enable <= 1'b0;
			interrupt_enable <= 1'b0;
			prescaler_select <= `PIT_PSC_RESET;
			reload_count <= `PIT_RELOAD_RESET;
		end else if (ctrl_wr) begin
			run_enable <= pwdata_i[`PIT_RUN_BIT];
			interrupt_enable <= pwdata_i[`PIT_IEN_BIT];
			prescaler_select <= pwdata_i[`PIT_PSC_HI:`PIT_PSC_LO];
			reload_count <= pwdata_i[`PIT_RELOAD_HI:`PIT_RELOAD_LO];
		end
	end

	// tick rate is the input clock over the selected divisor
	pit_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.restart_i(ctrl_wr),
		.code_i(prescaler_select),
		.tick_o(tick)
	);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			live_count <= `PIT_COUNT_RESET;
		end else if (ctrl_wr) begin
			live_count <= pwdata_i[`PIT_RELOAD_HI:`PIT_RELOAD_LO];
		end else if (tick_en) begin
			// zero and one handled by next-count wrap
			live_count <= pit_next_count(live_count, reload_count);
		end
		// no tick_en while stopped, count held
	end

	// Read of a set flag arms the clear; any later control write disarms
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			clear_armed <= 1'b0;
		end else if (ctrl_rd && expiry_flag) begin
			clear_armed <= 1'b1;
		end else if (ctrl_wr || !expiry_flag) begin
			clear_armed <= 1'b0;
		end
	end

	// set on expiry; set wins, write of one ignored
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			expiry_flag <= 1'b0;
		end else if (expire) begin
			expiry_flag <= 1'b1;
		end else if (ctrl_wr && clear_armed && !pwdata_i[`PIT_FLAG_BIT]) begin
			expiry_flag <= 1'b0;
		end
	end

	// Event status: sticky, cleared by write-one to the clear register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			evt_status <= `PIT_EVT_RESET;
			evt_enable <= `PIT_EVT_RESET;
		end else begin
			for (int i = 0; i < `PIT_EVT_WIDTH; i++) begin
				if (clr_wr && pwdata_i[i]) begin
					evt_status[i] <= 1'b0;
				end
			end
			if (expire) begin
				evt_status[`PIT_EVT_EXPIRY] <= 1'b1;
			end
			if (ctrl_wr) begin
				evt_status[`PIT_EVT_RESTART] <= 1'b1;
			end
			if (commit && pwrite_i && paddr_i == `PIT_ADDR_EVT_ENABLE) begin
				evt_enable <= pwdata_i[`PIT_EVT_WIDTH-1:0];
			end
		end
	end

	// gated by interrupt enable, events also by their enable; counting untouched
	// level request toward the interrupt controller
	// flag is sticky so the request persists
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= interrupt_enable &&
				(expiry_flag || |(evt_status & evt_enable));
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_expire;
		tick_en ##0 live_count == `PIT_COUNT_ONE ##0 !ctrl_wr;
	endsequence

	// No control write in the match, so the reload is still the one in force
	property p_reload_follows;
		s_expire |=> live_count == $past(reload_count);
	endproperty

	a_expiry_sets_flag: assert property (s_expire |=> expiry_flag)
		else $error("expiry flag not set at zero crossing");
	a_periodic_reload: assert property (p_reload_follows)
		else $error("counter did not reload after zero");
	a_hold_stopped: assert property (!run_enable && !ctrl_wr |=>
		$stable(live_count))
		else $error("count moved while stopped");
	a_irq_gated_off: assert property (!interrupt_enable |=> !irq_o)
		else $error("request raised with interrupt enable clear");
	a_write_one_keeps: assert property (expiry_flag && ctrl_wr &&
		pwdata_i[`PIT_FLAG_BIT] |=> expiry_flag)
		else $error("writing one cleared the expiry flag");
	a_clear_needs_read: assert property (expiry_flag && !clear_armed
		|=> expiry_flag)
		else $error("flag cleared without prior read");
	a_reserved_zero: assert property (state == PIT_BUS_RESP &&
		!pwrite_i && paddr_i == `PIT_ADDR_CTRL |->
		(prdata_o & ~`PIT_CTRL_READ_MASK) == `PIT_CTRL_RESET)
		else $error("reserved control bits read nonzero");
	a_reload_restart: assert property (ctrl_wr |=>
		live_count == $past(pwdata_i[`PIT_RELOAD_HI:`PIT_RELOAD_LO]))
		else $error("reload write did not restart counter");
	a_reset_prescale: assert property ($rose(rst_n_i) |->
		prescaler_select == `PIT_PSC_RESET)
		else $error("prescaler not divide-by-four after reset");
	// Request trails the flag by one cycle, so look two cycles on
	a_request_held: assert property (expiry_flag && interrupt_enable &&
		!ctrl_wr |=> ##1 irq_o)
		else $error("pending request dropped before clear");
	a_irq_follows_flag: assert property (expiry_flag &&
		interrupt_enable |=> irq_o)
		else $error("request missing while flag and enable set");

endmodule
`default_nettype wire

/* logic/pit_cfg.svh */
// Register map, field positions, reset values and divider codes of the timer
`ifndef PIT_CFG_SVH
`define PIT_CFG_SVH

`define PIT_ADDR_CTRL 32'h8007FC40
`define PIT_ADDR_COUNT 32'h8007FC44
`define PIT_ADDR_EVT_STATUS 32'h8007FC50
`define PIT_ADDR_EVT_CLEAR 32'h8007FC54
`define PIT_ADDR_EVT_ENABLE 32'h8007FC58

`define PIT_RUN_BIT 30
`define PIT_IEN_BIT 29
`define PIT_PSC_HI 26
`define PIT_PSC_LO 24
`define PIT_FLAG_BIT 16
`define PIT_RELOAD_HI 15
`define PIT_RELOAD_LO 0
`define PIT_CTRL_READ_MASK 32'h6701FFFF

`define PIT_CTRL_RESET 32'h00000000
`define PIT_PSC_RESET 3'h0
`define PIT_RELOAD_RESET 16'h0000
`define PIT_COUNT_RESET 16'h0000
`define PIT_COUNT_ONE 16'h0001

`define PIT_EVT_WIDTH 2
`define PIT_EVT_EXPIRY 0
`define PIT_EVT_RESTART 1
`define PIT_EVT_RESET 2'h0

`define PIT_PSC_DIV4 3'h0
`define PIT_PSC_DIV8 3'h1
`define PIT_PSC_DIV16 3'h2
`define PIT_PSC_DIV32 3'h3
`define PIT_MASK_DIV4 6'h03
`define PIT_MASK_DIV8 6'h07
`define PIT_MASK_DIV16 6'h0F
`define PIT_MASK_DIV32 6'h1F
`define PIT_MASK_DIV64 6'h3F
`define PIT_PSC_CNT_RESET 6'h00

`endif

/* logic/pit_pkg.sv */
// Types shared by the periodic interval timer modules
`include "pit_cfg.svh"
package pit_pkg;

	typedef enum logic [2:0] {
		PIT_BUS_IDLE = 3'b001,
		PIT_BUS_RESP = 3'b010,
		PIT_BUS_DONE = 3'b100
	} pit_bus_state_t;

	// Terminal value of the prescaler counter for a divider code
	function automatic logic [5:0] pit_div_mask(input logic [2:0] code);
		logic [5:0] mask;
		mask = `PIT_MASK_DIV64;
		unique case (code)
			`PIT_PSC_DIV4: mask = `PIT_MASK_DIV4;
			`PIT_PSC_DIV8: mask = `PIT_MASK_DIV8;
			`PIT_PSC_DIV16: mask = `PIT_MASK_DIV16;
			`PIT_PSC_DIV32: mask = `PIT_MASK_DIV32;
			default: mask = `PIT_MASK_DIV64;
		endcase
		return mask;
	endfunction

endpackage

/* logic/pit_prescaler.sv */
// Clock prescaler producing the one-cycle timer tick enable
`timescale 1ns/10ps
`default_nettype none
`include "pit_cfg.svh"
module pit_prescaler
	import pit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic restart_i,
	input wire logic [2:0] code_i,
	output logic tick_o
);

	logic [5:0] cnt;
	logic [5:0] lim;

	assign lim = pit_div_mask(code_i);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || restart_i) begin
			cnt <= `PIT_PSC_CNT_RESET;
			tick_o <= 1'b0;
		end else if (cnt >= lim) begin
			// Code change mid-period wraps at once, never overshoots
			cnt <= `PIT_PSC_CNT_RESET;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 6'h01;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* testbench/pit_irq_ctrl_model.sv */
// Interrupt controller stand-in counting timer requests
`timescale 1ns/10ps
`default_nettype none
module pit_irq_ctrl_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic irq_i,
	output logic [7:0] taken_o
);
	logic irq_q;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
			taken_o <= 8'h00;
		end else begin
			irq_q <= irq_i;
			if (irq_i && !irq_q) begin
				taken_o <= taken_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/periodic_interval_timer_tb_top.sv */
// Self-checking bench for the periodic interval timer
`timescale 1ns/10ps
`default_nettype none
`include "pit_cfg.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	mismatches++; $display("Error at %0t: got %0h want %0h", $time, \
	got, exp); end end
module periodic_interval_timer_tb_top;
	typedef struct {logic [2:0] code; logic [15:0] rld; int cyc;} pit_row_t;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic [31:0] rd;
	logic pready_o;
	logic pslverr_o;
	logic err;
	logic irq_o;
	logic [7:0] taken;
	int mismatches = 0;
	int checks_done = 0;
	int n;
	// Reload times divisor, plus registered tick and request latency
	pit_row_t rows [7] = '{'{3'h0, 16'h0001, 6}, '{3'h1, 16'h0003, 26},
		'{3'h2, 16'h0002, 34}, '{3'h3, 16'h0001, 34},
		'{3'h4, 16'h0001, 66}, '{3'h5, 16'h0001, 66},
		'{3'h7, 16'h0002, 130}};

	pit_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .irq_o(irq_o));
	pit_irq_ctrl_model i_icm (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.irq_i(irq_o), .taken_o(taken));

	always #25 clk_i = ~clk_i;

	function automatic logic [31:0] ctl(input logic run, input logic ien,
		input logic [2:0] c, input logic [15:0] r);
		return {1'b0, run, ien, 2'b00, c, 7'h00, 1'b0, r};
	endfunction

	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task automatic wait_irq();
		n = 0;
		while (irq_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask

	task automatic complete_run();
		$display("Mismatches %0d, checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(50 * 60000);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h00000000)
		xfer(1'b1, `PIT_ADDR_CTRL, 32'hFFFFFFFF);
		xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h6700FFFF)
		foreach (rows[i]) begin
			xfer(1'b1, `PIT_ADDR_CTRL, ctl(1, 1, rows[i].code, rows[i].rld));
			wait_irq();
			`CHK(n, rows[i].cyc)
			// Odd rows try to clear the flag by writing one
			xfer(1'b1, `PIT_ADDR_CTRL,
				ctl(0, 1, 3'h0, 16'h0009) | {15'h0, i[0], 16'h0});
			settle();
			`CHK(irq_o, 1'b1)
			xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
			`CHK(rd[16], 1'b1)
			// Interrupt enable kept on so only the flag can drop the request
			xfer(1'b1, `PIT_ADDR_CTRL, ctl(0, 1, 3'h0, 16'h0009));
			settle();
			`CHK(irq_o, 1'b0)
		end
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(1, 0, 3'h0, 16'h0002));
		repeat (20) @(posedge clk_i);
		#1;
		`CHK(irq_o, 1'b0)
		xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
		`CHK(rd[16], 1'b1)
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(0, 0, 3'h0, 16'h0005));
		xfer(1'b0, `PIT_ADDR_COUNT, 32'h0);
		`CHK(rd, 32'h00000005)
		xfer(1'b1, `PIT_ADDR_COUNT, 32'h00001234);
		repeat (40) @(posedge clk_i);
		xfer(1'b0, `PIT_ADDR_COUNT, 32'h0);
		`CHK(rd, 32'h00000005)
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(1, 0, 3'h0, 16'h0000));
		xfer(1'b0, `PIT_ADDR_COUNT, 32'h0);
		`CHK(rd, 32'h00000000)
		xfer(1'b0, `PIT_ADDR_COUNT, 32'h0);
		`CHK(rd, 32'h0000FFFF)
		xfer(1'b0, 32'h8007FC48, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		// Drop stale expiry events so the request waits for a fresh one
		xfer(1'b1, `PIT_ADDR_EVT_CLEAR, 32'h3);
		xfer(1'b1, `PIT_ADDR_EVT_ENABLE, 32'h1);
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(1, 1, 3'h0, 16'h0002));
		wait_irq();
		`CHK(n, 10)
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(0, 1, 3'h0, 16'h0002));
		xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(0, 1, 3'h0, 16'h0002));
		settle();
		`CHK(irq_o, 1'b1)
		xfer(1'b0, `PIT_ADDR_EVT_STATUS, 32'h0);
		`CHK(rd, 32'h00000003)
		xfer(1'b1, `PIT_ADDR_EVT_ENABLE, 32'h0);
		settle();
		`CHK(irq_o, 1'b0)
		xfer(1'b1, `PIT_ADDR_EVT_CLEAR, 32'h3);
		xfer(1'b1, `PIT_ADDR_EVT_ENABLE, 32'h1);
		xfer(1'b0, `PIT_ADDR_EVT_STATUS, 32'h0);
		`CHK({irq_o, rd}, {1'b0, 32'h0})
		`CHK(taken, 8'h08)
		xfer(1'b1, `PIT_ADDR_CTRL, ctl(1, 1, 3'h3, 16'h0001));
		wait_irq();
		`CHK(n, 34)
		xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
		`CHK({irq_o, rd}, {1'b1, 32'h63010001})
		// Mid-run reset with a request pending and read data standing
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
		`CHK({irq_o, pready_o, pslverr_o, prdata_o}, 35'h0)
		xfer(1'b0, `PIT_ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h00000000)
		complete_run();
	end
endmodule
`default_nettype wire
